// [hw/lbp_pkg.sv]
// package for the breathing/blinking pwm block: register map, field layout, constants
// assumes a 32-bit avalon-mm slave with word-aligned registers
package lbp_pkg;
    // register byte offsets
    localparam logic [4:0] OFF_CFG   = 5'h00;
    localparam logic [4:0] OFF_LIM   = 5'h04;
    localparam logic [4:0] OFF_DLY   = 5'h08;
    localparam logic [4:0] OFF_STEP  = 5'h0C;
    localparam logic [4:0] OFF_INT   = 5'h10;
    localparam logic [4:0] OFF_STAT  = 5'h14;
    // configuration field positions
    localparam int CFG_CTRL_LO  = 0;
    localparam int CFG_CLKSRC   = 2;
    localparam int CFG_SYM      = 3;
    localparam int CFG_WID_LO   = 4;
    localparam int CFG_UPD      = 6;
    localparam int CFG_RST      = 7;
    localparam int CFG_WDT_LO   = 8;
    // limit and delay field positions
    localparam int LIM_MIN_LO   = 0;
    localparam int LIM_MAX_LO   = 8;
    localparam int DLY_LD_LO    = 0;
    localparam int DLY_HD_LO    = 12;
    // reset values
    localparam logic [7:0]  WDT_RELOAD_RST = 8'h14;
    localparam logic [31:0] ZERO32         = 32'h0000_0000;
    // counter wrap values for width select
    localparam logic [7:0] WRAP8 = 8'hFF;
    localparam logic [7:0] WRAP7 = 8'h7F;
    localparam logic [7:0] WRAP6 = 8'h3F;
    // width select codes
    localparam logic [1:0] WID8 = 2'h0;
    localparam logic [1:0] WID7 = 2'h1;
    // mode control encoding
    typedef enum logic [1:0] {
        LBP_OFF   = 2'b00,
        LBP_BREATH = 2'b01,
        LBP_BLINK = 2'b10,
        LBP_ON    = 2'b11
    } lbp_mode_t;
    // breathing ramp state
    typedef enum logic [1:0] {
        LBP_RISE  = 2'b00,
        LBP_HOLDH = 2'b01,
        LBP_FALL  = 2'b10,
        LBP_HOLDL = 2'b11
    } lbp_phase_t;
endpackage

// [hw/lbp_pwm.sv]
// breathing / blinking pwm with watchdog, avalon-mm register slave
// assumes one clock, clk_32k_tick and tick_5hz are one-cycle enables synchronous to clk
//
// Functional notes
// - watchdog counts only in blinking mode on main clock source
// - watchdog is 8-bit down counter with 8-bit reload field in config
// - system reset loads watchdog with reload default 14h
// - config write or min-byte write reloads the watchdog counter
// - nonzero watchdog decrements once per 5 Hz tick
// - one-to-zero step pulses irq and sets mode to always-on only
// - timeout irq lasts exactly one clock cycle
// - without ticks watchdog holds, resumes from held value
// - reload zero disables watchdog; each count is 200 ms
// - breathing phase counter wraps at 255, 127 or 63 by width select
// - output high while phase counter below duty value
// - off or reset bit clears all counters except the watchdog, and the working registers
// - duty rises by segment step at segment update interval rate, holds at max for high hold
// - then falls by step, holds at min for low hold, repeats
// - symmetric segment index is duty bits 7:5, selecting 4-bit fields
// - asymmetric index is falling flag and duty bits 7:6
// - blinking delay counter reloads from prescale, zero clocks pwm counter
// - prescale zero passes input clock straight to pwm counter
// - blinking counter always 8-bit, frequency clock/(256*(ld+1))
// - duty zero fully off, mode always-on forces fully on
// - step, interval, max and hold ignored in blinking mode
// - blinking duty from min field, prescale from low-delay field
// - limit writes held, applied when pwm counter wraps to zero
//
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module lbp_pwm
    import lbp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        clk_32k_tick,
    input  wire logic        tick_5hz,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic             pwm_out,
    output logic             pwm_watchdog_timeout_irq
);
    typedef struct packed {
        logic [31:0] cfg;
        logic [15:0] lim_hold;
        logic [15:0] lim;
        logic [23:0] dly_hold;
        logic [23:0] dly;
        logic [31:0] step_hold;
        logic [31:0] segment_step_sizes;
        logic [31:0] int_hold;
        logic [31:0] segment_update_intervals;
        logic [7:0]  pwm_phase_counter;
        logic [11:0] delay_cnt;
        logic [11:0] hold_cnt;
        logic [3:0]  int_cnt;
        logic [7:0]  duty;
        lbp_phase_t  phase;
        logic [7:0]  wdt_cnt;
        logic        irq;
        logic        out;
        logic        ack;
        logic [31:0] rdata;
    } lbp_state_t;

    lbp_state_t st;
    lbp_state_t next_st;

    // byte-lane merge for avalon writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // pick 4-bit field by segment index
    function automatic logic [3:0] seg_field(input logic [31:0] f, input logic [2:0] idx);
        return f[idx*4 +: 4];
    endfunction

    // general-purpose operation: blinking arrangement on the main clock
    function automatic logic gp_main(input logic [31:0] cfg);
        return (cfg[CFG_CTRL_LO +: 2] == LBP_BLINK) && cfg[CFG_CLKSRC];
    endfunction

    logic        wr_hit;
    logic        rd_hit;
    logic        wr_take;
    logic [31:0] lim_merged;
    logic [31:0] dly_merged;
    logic [1:0]  mode;
    logic [1:0]  wid;
    logic [7:0]  wrap;
    logic [7:0]  lim_min;
    logic [7:0]  lim_max;
    logic [11:0] ld;
    logic [11:0] hd;
    logic [2:0]  seg;
    logic        tick_in;
    logic        pwm_tick;
    logic        wrapping;
    logic [8:0]  sum;
    logic [8:0]  diff;

    // decoded fields of the live registers
    always_comb begin
        mode    = st.cfg[CFG_CTRL_LO +: 2];
        wid     = st.cfg[CFG_WID_LO +: 2];
        lim_min = st.lim[LIM_MIN_LO +: 8];
        lim_max = st.lim[LIM_MAX_LO +: 8];
        ld      = st.dly[DLY_LD_LO +: 12];
        hd      = st.dly[DLY_HD_LO +: 12];
        wr_hit  = avs_write && !st.ack;
        rd_hit  = avs_read && !st.ack;
        wr_take = avs_write && st.ack; // commit only on the edge where waitrequest is low
        // narrow holding registers merged at full width, cut on use
        lim_merged = merge({16'h0000, st.lim_hold}, avs_writedata, avs_byteenable);
        dly_merged = merge({8'h00, st.dly_hold}, avs_writedata, avs_byteenable);
        if (mode == LBP_BLINK) begin
            wrap = WRAP8;
        end else if (wid == WID8) begin
            wrap = WRAP8;
        end else if (wid == WID7) begin
            wrap = WRAP7;
        end else begin
            wrap = WRAP6;
        end
        if (st.cfg[CFG_SYM]) begin
            seg = st.duty[7:5];
        end else begin
            seg = {st.phase == LBP_FALL || st.phase == LBP_HOLDH, st.duty[7:6]};
        end
        // main clock or 32k tick feeds the prescaler
        tick_in  = gp_main(st.cfg) ? 1'b1 : clk_32k_tick;
        pwm_tick = tick_in && (st.delay_cnt == 12'h000);
        wrapping = pwm_tick && (st.pwm_phase_counter == wrap);
        sum  = {1'b0, st.duty} + {5'h00, seg_field(st.segment_step_sizes, seg)};
        diff = {1'b0, st.duty} - {5'h00, seg_field(st.segment_step_sizes, seg)};
    end

    // next-state logic
    always_comb begin
        next_st = st;
        next_st.irq = 1'b0;
        next_st.ack = 1'b0;
        // avalon slave: one wait cycle, ack on second
        if (wr_hit || rd_hit) begin
            next_st.ack = 1'b1;
        end
        if (rd_hit) begin
            case (avs_address)
                OFF_CFG:  next_st.rdata = st.cfg;
                OFF_LIM:  next_st.rdata = {16'h0000, st.lim_hold};
                OFF_DLY:  next_st.rdata = {8'h00, st.dly_hold};
                OFF_STEP: next_st.rdata = st.step_hold;
                OFF_INT:  next_st.rdata = st.int_hold;
                OFF_STAT: next_st.rdata = {st.wdt_cnt, st.duty, st.pwm_phase_counter, 6'h00, st.phase};
                default:  next_st.rdata = ZERO32;
            endcase
        end
        // counters and duty machine
        if (pwm_tick) begin
            next_st.pwm_phase_counter = wrapping ? 8'h00 : st.pwm_phase_counter + 8'h01;
        end
        if (tick_in) begin
            next_st.delay_cnt = (st.delay_cnt == 12'h000) ? ld : st.delay_cnt - 12'h001;
        end
        if (mode == LBP_BLINK) begin
            next_st.duty = lim_min;
        end else if (mode == LBP_BREATH && wrapping) begin
            // breathing: one ramp decision per period
            case (st.phase)
                LBP_RISE: begin
                    if (st.int_cnt >= seg_field(st.segment_update_intervals, seg)) begin
                        next_st.int_cnt = 4'h0;
                        if (sum >= {1'b0, lim_max}) begin
                            next_st.duty  = lim_max;
                            next_st.phase = LBP_HOLDH;
                        end else begin
                            next_st.duty = sum[7:0];
                        end
                    end else begin
                        next_st.int_cnt = st.int_cnt + 4'h1;
                    end
                end
                LBP_HOLDH: begin
                    if (st.hold_cnt >= hd) begin
                        next_st.hold_cnt = 12'h000;
                        next_st.phase    = LBP_FALL;
                    end else begin
                        next_st.hold_cnt = st.hold_cnt + 12'h001;
                    end
                end
                LBP_FALL: begin
                    if (st.int_cnt >= seg_field(st.segment_update_intervals, seg)) begin
                        next_st.int_cnt = 4'h0;
                        if (diff[8] || diff[7:0] <= lim_min) begin
                            next_st.duty  = lim_min;
                            next_st.phase = LBP_HOLDL;
                        end else begin
                            next_st.duty = diff[7:0];
                        end
                    end else begin
                        next_st.int_cnt = st.int_cnt + 4'h1;
                    end
                end
                LBP_HOLDL: begin
                    if (st.hold_cnt >= ld) begin
                        next_st.hold_cnt = 12'h000;
                        next_st.phase    = LBP_RISE;
                    end else begin
                        next_st.hold_cnt = st.hold_cnt + 12'h001;
                    end
                end
                default: next_st.phase = LBP_RISE;
            endcase
        end
        // limit holding register copied at period end, the other holding registers only when the update bit is set
        if (wrapping) begin
            next_st.lim = st.lim_hold;
            if (st.cfg[CFG_UPD]) begin
                next_st.dly                      = st.dly_hold;
                next_st.segment_step_sizes       = st.step_hold;
                next_st.segment_update_intervals = st.int_hold;
            end
        end
        // watchdog
        if (gp_main(st.cfg) && tick_5hz && st.wdt_cnt != 8'h00) begin
            next_st.wdt_cnt = st.wdt_cnt - 8'h01;
            if (st.wdt_cnt == 8'h01) begin
                next_st.irq                   = 1'b1;
                next_st.cfg[CFG_CTRL_LO +: 2] = LBP_ON;
            end
        end
        // register writes, taken when the answer is given
        if (wr_take) begin
            case (avs_address)
                OFF_CFG: begin
                    next_st.cfg     = merge(st.cfg, avs_writedata, avs_byteenable);
                    next_st.wdt_cnt = next_st.cfg[CFG_WDT_LO +: 8];
                end
                OFF_LIM: begin
                    next_st.lim_hold = lim_merged[15:0];
                    if (avs_byteenable[0]) begin
                        next_st.wdt_cnt = st.cfg[CFG_WDT_LO +: 8];
                    end
                end
                OFF_DLY:  next_st.dly_hold  = dly_merged[23:0];
                OFF_STEP: next_st.step_hold = merge(st.step_hold, avs_writedata, avs_byteenable);
                OFF_INT:  next_st.int_hold  = merge(st.int_hold, avs_writedata, avs_byteenable);
                default: ;
            endcase
        end
        // off or reset bit clears working state
        if (next_st.cfg[CFG_CTRL_LO +: 2] == LBP_OFF || next_st.cfg[CFG_RST]) begin
            next_st.pwm_phase_counter        = 8'h00;
            next_st.delay_cnt                = 12'h000;
            next_st.hold_cnt                 = 12'h000;
            next_st.int_cnt                  = 4'h0;
            next_st.duty                     = 8'h00;
            next_st.phase                    = LBP_RISE;
            next_st.lim                      = 16'h0000;
            next_st.dly                      = 24'h000000;
            next_st.segment_step_sizes       = ZERO32;
            next_st.segment_update_intervals = ZERO32;
            next_st.cfg[CFG_RST]             = 1'b0;
        end
        // output drive
        case (lbp_mode_t'(next_st.cfg[CFG_CTRL_LO +: 2]))
            LBP_OFF: next_st.out = 1'b0;
            LBP_ON:  next_st.out = 1'b1;
            default: next_st.out = next_st.pwm_phase_counter < next_st.duty;
        endcase
    end

    // state register
    always_ff @(posedge clk) begin
        if (reset) begin
            st         <= '0;
            st.cfg     <= {16'h0000, WDT_RELOAD_RST, 8'h00};
            st.wdt_cnt <= WDT_RELOAD_RST;
        end else begin
            st <= next_st;
        end
    end

    assign avs_readdata             = st.rdata;
    assign avs_waitrequest          = !st.ack;
    assign pwm_out                  = st.out;
    assign pwm_watchdog_timeout_irq = st.irq;
endmodule

// [testbench/lbp_pwm_asserts.sv]
// checker for the pwm block: bus handshake timing and watchdog timeout pulse
// assumes it is bound to lbp_pwm and sees only that module's ports
`timescale 1ns/1ps
module lbp_pwm_checker (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        tick_5hz,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        pwm_out,
    input wire logic        pwm_watchdog_timeout_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // bus answers on the second edge of a request, for one cycle only
    property p_ack_next; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
    a_ack_next: assert property (p_ack_next) else $error("no answer one cycle after request");
    property p_ack_one; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_ack_one: assert property (p_ack_one) else $error("answer held longer than one cycle");
    property p_wait_cause; !avs_waitrequest |-> $past(avs_read || avs_write); endproperty
    a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
    property p_idle_wait; !(avs_read || avs_write) |-> avs_waitrequest; endproperty
    a_idle_wait: assert property (p_idle_wait) else $error("waitrequest low while idle");
    property p_rdata_hold; avs_read && !avs_waitrequest |=> $stable(avs_readdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed after read");
    // timeout pulse: one cycle, caused by a tick, forces output on
    property p_irq_pulse; pwm_watchdog_timeout_irq |=> !pwm_watchdog_timeout_irq; endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("timeout pulse too long");
    property p_irq_cause; pwm_watchdog_timeout_irq |-> $past(tick_5hz) || $past(tick_5hz, 2); endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("timeout without tick");
    property p_irq_on; pwm_watchdog_timeout_irq && !avs_write |-> ##[1:3] pwm_out; endproperty
    a_irq_on: assert property (p_irq_on) else $error("output not forced on");
endmodule
bind lbp_pwm lbp_pwm_checker u_chk (.clk(clk), .reset(reset), .tick_5hz(tick_5hz), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pwm_out(pwm_out), .pwm_watchdog_timeout_irq(pwm_watchdog_timeout_irq));

// [testbench/lbp_led_model.sv]
// led load model: counts cycles in which the pwm output drives it on
// assumes count_en is held high for the measuring window and low between
`timescale 1ns/1ps
module lbp_led_model (
    input wire logic clk,
    input wire logic count_en,
    input wire logic pwm_out,
    output int       on_cycles
);
    // accumulate lit cycles, clear between windows
    always @(posedge clk) begin
        if (!count_en) on_cycles <= 0;
        else if (pwm_out === 1'b1) on_cycles <= on_cycles + 1;
    end
endmodule

// [testbench/tb.sv]
// testbench for the pwm block: registers, watchdog, blink duty and modes
// assumes lbp_pwm with avalon-mm slave and one-cycle tick enables on clk
`timescale 1ns/1ps
module tb;
    import lbp_pkg::*;
    logic clk = 0, reset = 1, clk_32k_tick = 0, tick_5hz = 0, avs_read = 0, avs_write = 0, count_en = 0;
    logic [4:0]  avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic [3:0]  avs_byteenable = 4'hF;
    logic        avs_waitrequest, pwm_out, pwm_watchdog_timeout_irq;
    int          err_count = 0, comparisons = 0, irq_seen = 0, on_cycles;
    logic [2:0]  div = 3'h0;
    lbp_pwm DUT (.clk(clk), .reset(reset), .clk_32k_tick(clk_32k_tick), .tick_5hz(tick_5hz),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .pwm_out(pwm_out), .pwm_watchdog_timeout_irq(pwm_watchdog_timeout_irq));
    lbp_led_model u_led (.clk(clk), .count_en(count_en), .pwm_out(pwm_out), .on_cycles(on_cycles));
    initial forever #5 clk = ~clk;
    // slow tick enable and timeout pulse counting
    always @(posedge clk) begin
        div <= div + 3'h1;
        clk_32k_tick <= (div == 3'h7);
        if (pwm_watchdog_timeout_irq === 1'b1) irq_seen <= irq_seen + 1;
    end
    task automatic finish_test;
        if (err_count == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one bus cycle, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        if (wr) avs_write <= 1'b1;
        else avs_read <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        check32(32'(n), 32'h2); // answer on the second edge
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hF);
        check32(rd, exp);
    endtask
    task automatic wdt_chk(input logic [7:0] exp);
        bus(1'b0, OFF_STAT, 32'h0, 4'hF);
        check32({24'h0, rd[31:24]}, {24'h0, exp});
    endtask
    task automatic tick;
        @(posedge clk);
        tick_5hz <= 1'b1;
        @(posedge clk);
        tick_5hz <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    // count lit cycles over a window of n clocks
    task automatic lit_chk(input int n, input int exp);
        repeat (800) @(posedge clk);
        count_en <= 1'b1;
        repeat (n) @(posedge clk);
        count_en <= 1'b0;
        @(negedge clk);
        check32(32'(on_cycles), 32'(exp));
    endtask
    task automatic t_reset;
        rd_chk(OFF_CFG, 32'h0000_1400);
        wdt_chk(8'h14);
        rd_chk(5'h18, 32'h0);
    endtask
    task automatic t_blink;
        wr(OFF_CFG, 32'h0000_0006);
        wr(OFF_LIM, 32'h0000_FF40);
        lit_chk(512, 128);
        wr(OFF_LIM, 32'h0000_0000);
        lit_chk(512, 0);
        wr(OFF_LIM, 32'h0000_00FF);
        lit_chk(512, 510);
        wr(OFF_CFG, 32'h0000_0046);
        wr(OFF_DLY, 32'h0000_0001);
        wr(OFF_LIM, 32'h0000_0040);
        lit_chk(1024, 256);
    endtask
    task automatic t_watchdog;
        wr(OFF_DLY, 32'h0000_0000);
        wr(OFF_LIM, 32'h0000_0000);
        wr(OFF_CFG, 32'h0000_0306);
        tick();
        tick();
        repeat (50) @(posedge clk);
        wdt_chk(8'h01);
        check32(32'(irq_seen), 32'h0);
        tick();
        check32(32'(irq_seen), 32'h1);
        rd_chk(OFF_CFG, 32'h0000_0307);
        lit_chk(256, 256);
    endtask
    task automatic t_reload;
        wr(OFF_CFG, 32'h0000_0306);
        wdt_chk(8'h03);
        tick();
        wdt_chk(8'h02);
        bus(1'b1, OFF_LIM, 32'h0000_0000, 4'h1);
        wdt_chk(8'h03);
        wr(OFF_CFG, 32'h0000_0206);
        tick();
        wdt_chk(8'h01);
        wr(OFF_CFG, 32'h0000_0302);
        tick();
        wdt_chk(8'h03);
        wr(OFF_CFG, 32'h0000_0006);
        repeat (3) tick();
        check32(32'(irq_seen), 32'h1);
        wdt_chk(8'h00);
    endtask
    // blinking on the slow tick; limits wait for the period end
    task automatic t_slow;
        wr(OFF_CFG, 32'h0000_0000);
        wr(OFF_CFG, 32'h0000_0002);
        wr(OFF_LIM, 32'h0000_0040);
        bus(1'b0, OFF_STAT, 32'h0, 4'hF);
        check32({24'h0, rd[23:16]}, 32'h0);
        repeat (2100) @(posedge clk);
        lit_chk(2048, 512);
    endtask
    task automatic t_modes;
        wr(OFF_CFG, 32'h0000_0003);
        lit_chk(256, 256);
        wr(OFF_CFG, 32'h0000_0000);
        lit_chk(256, 0);
        rd_chk(OFF_STAT, 32'h0000_0000);
        wr(OFF_CFG, 32'h0000_0021);
        repeat (800) @(posedge clk);
        bus(1'b0, OFF_STAT, 32'h0, 4'hF);
        check32({30'h0, rd[15:14]}, 32'h0);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_blink();
        t_watchdog();
        t_reload();
        t_slow();
        t_modes();
        finish_test();
    end
    // watchdog for a hung bus or model
    initial begin
        #400000;
        err_count++;
        finish_test();
    end
endmodule
